// ===== design/smrb_cfg.svh
// Register offsets, field positions, reset values and codes for the mode register block
`ifndef SMRB_CFG_SVH
`define SMRB_CFG_SVH
// ==========================================
// Register addresses
`define SMRB_ADDR_INFO 8'h00
`define SMRB_ADDR_FEAT 8'h01
// ==========================================
// Information register fields
`define SMRB_INFO_INIT_BIT 0
`define SMRB_INFO_CLASS_BIT 1
`define SMRB_INFO_DNV_BIT 2
`define SMRB_INFO_ZQ_LO 3
`define SMRB_INFO_ZQ_HI 4
`define SMRB_CLASS_SDRAM 1'b0
`define SMRB_DNV_UNSUP 1'b0
`define SMRB_ZQ_UNSUP 2'h0
`define SMRB_ZQ_VDDCA 2'h1
`define SMRB_ZQ_GND 2'h2
`define SMRB_ZQ_OK 2'h3
// ==========================================
// Feature register fields and codes
`define SMRB_FEAT_BL_LO 0
`define SMRB_FEAT_BL_HI 2
`define SMRB_FEAT_BT_BIT 3
`define SMRB_FEAT_WC_BIT 4
`define SMRB_FEAT_WR_LO 5
`define SMRB_FEAT_WR_HI 7
`define SMRB_BL4 3'h2
`define SMRB_BL8 3'h3
`define SMRB_BL16 3'h4
`define SMRB_WR_MIN 3'h1
`define SMRB_WR_MAX 3'h6
`define SMRB_WR_OFFSET 4'h2
`define SMRB_FEAT_RESET 8'h22
// ==========================================
// Timing
`define SMRB_CLK_PERIOD_NS 100
`define SMRB_INIT_TIME_NS 200000
`define SMRB_INIT_CYCLES (`SMRB_INIT_TIME_NS / `SMRB_CLK_PERIOD_NS)
`endif

// ===== design/smrb_pkg.sv
// Types for the mode register block
package smrb_pkg;
   typedef enum logic [1:0] {SMRB_BLEN4, SMRB_BLEN8, SMRB_BLEN16} smrb_blen_t;
   typedef enum logic [1:0] {SMRB_IDLE, SMRB_BURST} smrb_state_t;
endpackage : smrb_pkg

// ===== design/smrb_mode_regs.sv
// Device information and feature mode registers with burst column order
`timescale 1ns/100ps
`default_nettype none
`include "smrb_cfg.svh"

// How it works
// [RL1] Information bit 0 reads one until auto-initialization completes, then zero.
// [RL2] Device class bit and data-not-valid bit both read zero.
// [RL3] Two-bit impedance test field: 00 unsupported, 01 supply/float, 10 ground short.
// [RL4] Field reads 11 when test passes; resistor value not validated.
// [RL5] Test field updates only when the calibration-init write command finishes.
// [RL6] On result 01 or 10 use factory trim and ignore later calibration.
// [RL7] Pin tied to supply for default calibration reports 01.
// [RL8] Burst length codes 010/011/100 give 4/8/16; others reserved, not written.
// [RL9] Bit 3 picks sequential or interleaved; bit 4 picks wrap or no wrap.
// [RL10] Upper three bits give write recovery 3 to 8; others reserved.
// [RL11] Auto-precharge write starts precharge after programmed recovery cycles.
// [RL12] Lowest column bit is not carried and taken as zero.
// [RL13] Four-beat wrap: start from two low bits, order independent of type.
// [RL14] Eight-beat wrap: sequential mod 8, interleaved start xor beat.
// [RL15] Sixteen-beat: sequential mod 16 wrapped; interleave and no-wrap forbidden.
// [RL16] No-wrap only for four-beat bursts, running y to y+3.
// [RL17] Controller avoids no-wrap starts at page and sub-page edges.
// [RL18] Read command reads information, write command writes feature register.
// [RL19] Reserved bits are written zero and read back zero.
// [RL20] Reading write-only or reserved address gives undefined data, strobe still toggles.
module smrb_mode_regs
   import smrb_pkg::*;
#(
   parameter int unsigned INIT_CYCLES = `SMRB_INIT_CYCLES,
   parameter int unsigned COL_W = 10
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic mrr_req,
   input wire logic mrw_req,
   input wire logic [7:0] mr_addr,
   input wire logic [7:0] mr_wdata,
   input wire logic zq_cal_done,
   input wire logic [1:0] zq_test_code,
   input wire logic zq_cal_req,
   input wire logic col_req,
   input wire logic col_write,
   input wire logic col_ap,
   input wire logic [COL_W-1:0] col_addr,
   output logic mrr_valid,
   output logic mrr_strobe,
   output logic [7:0] mrr_data,
   output logic zq_cal_start,
   output logic factory_trim,
   output logic beat_valid,
   output logic [COL_W-1:0] beat_col,
   output logic beat_last,
   output logic [2:0] burst_len_code,
   output logic burst_interleave,
   output logic burst_no_wrap,
   output logic [3:0] write_recovery_cycles,
   output logic precharge_start
);

   // ==========================================
   // Elaboration checks
   initial begin
      if (COL_W < 5 || INIT_CYCLES < 1) begin
         $error("smrb_mode_regs: COL_W must be at least 5 and INIT_CYCLES at least 1");
      end
   end

   // ==========================================
   // Decoding helpers
   function automatic smrb_blen_t decode_blen(input logic [2:0] code);
      smrb_blen_t b;
      b = SMRB_BLEN4;
      if (code == `SMRB_BL8) begin
         b = SMRB_BLEN8;
      end else if (code == `SMRB_BL16) begin
         b = SMRB_BLEN16;
      end
      return b;
   endfunction : decode_blen

   function automatic logic [4:0] beats_of(input smrb_blen_t b);
      logic [4:0] n;
      n = 5'h04;
      if (b == SMRB_BLEN8) begin
         n = 5'h08;
      end else if (b == SMRB_BLEN16) begin
         n = 5'h10;
      end
      return n;
   endfunction : beats_of

   // ==========================================
   // Auto-initialization counter
   logic [31:0] init_count;
   logic init_busy;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         init_count <= 32'h0;
      end else if (init_busy) begin
         init_count <= init_count + 32'h1;
      end
   end
   // [RL1] init status bit
   assign init_busy = init_count < INIT_CYCLES;

   // ==========================================
   // Impedance self-test result
   logic [1:0] zq_result;
   logic zq_locked;
   // Results 01 and 10 mean an assembly fault, so calibration stops until reset clears the result
   // [RL6] lock on fault
   assign zq_locked = (zq_result == `SMRB_ZQ_VDDCA) || (zq_result == `SMRB_ZQ_GND);
   assign factory_trim = zq_locked;
   assign zq_cal_start = zq_cal_req && !zq_locked;
   // [RL5] update on completion
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         zq_result <= `SMRB_ZQ_UNSUP;
      end else if (zq_cal_done && !zq_locked) begin
         // [RL3] [RL4] [RL7] code from pin checker
         zq_result <= zq_test_code;
      end
   end

   // ==========================================
   // Feature register write
   logic [7:0] feat;
   wire feat_wr = mrw_req && (mr_addr == `SMRB_ADDR_FEAT);
   // [RL18] write path, read-only address ignored
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         feat <= `SMRB_FEAT_RESET;
      end else if (feat_wr) begin
         feat <= mr_wdata;
      end
   end
   // [RL8] [RL9] [RL10] field decode
   assign burst_len_code = feat[`SMRB_FEAT_BL_HI:`SMRB_FEAT_BL_LO];
   assign burst_interleave = feat[`SMRB_FEAT_BT_BIT];
   assign burst_no_wrap = feat[`SMRB_FEAT_WC_BIT];
   wire [2:0] wr_code = feat[`SMRB_FEAT_WR_HI:`SMRB_FEAT_WR_LO];
   assign write_recovery_cycles = {1'b0, wr_code} + `SMRB_WR_OFFSET;
   wire smrb_blen_t blen = decode_blen(burst_len_code);

   // ==========================================
   // Mode register read
   wire [7:0] info_word;
   // [RL2] [RL19] fixed and reserved bits zero
   assign info_word = {3'h0, zq_result, `SMRB_DNV_UNSUP, `SMRB_CLASS_SDRAM, init_busy};
   // [RL20] other addresses give don't-care zeros, strobe still runs
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mrr_valid <= 1'b0;
         mrr_data <= 8'h00;
      end else begin
         mrr_valid <= mrr_req;
         if (mrr_req) begin
            mrr_data <= (mr_addr == `SMRB_ADDR_INFO) ? info_word : 8'h00;
         end
      end
   end
   assign mrr_strobe = mrr_valid;

   // ==========================================
   // Burst sequencer
   smrb_state_t state;
   logic [COL_W-1:0] start_col;
   logic [3:0] beat_idx;
   logic [4:0] beat_total;
   logic burst_il;
   logic burst_nw;
   logic burst_wr_ap;
   logic [3:0] wr_count;
   logic wr_pending;
   // [RL12] low column bit forced to zero
   wire [COL_W-1:0] start_in = {col_addr[COL_W-1:1], 1'b0};
   wire [3:0] mask4 = beat_total[4] ? 4'hf : (beat_total[3] ? 4'h7 : 4'h3);
   wire [3:0] base4 = start_col[3:0];
   wire [3:0] seq_off = base4 + beat_idx;
   wire [3:0] il_off = base4 ^ beat_idx;
   // [RL13] [RL14] [RL15] wrapped order within aligned block
   wire [3:0] wrap_off = burst_il ? il_off : seq_off;
   wire [COL_W-1:0] wrap_col = {start_col[COL_W-1:4], (base4 & ~mask4) | (wrap_off & mask4)};
   // [RL16] no-wrap runs straight upward
   wire [COL_W-1:0] nw_col = start_col + {{(COL_W-4){1'b0}}, beat_idx};
   wire last_now = ({1'b0, beat_idx} == beat_total - 5'h01);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state <= SMRB_IDLE;
         start_col <= '0;
         beat_idx <= 4'h0;
         beat_total <= 5'h04;
         burst_il <= 1'b0;
         burst_nw <= 1'b0;
         burst_wr_ap <= 1'b0;
      end else begin
         unique case (state)
            SMRB_IDLE: begin
               if (col_req) begin
                  state <= SMRB_BURST;
                  start_col <= start_in;
                  beat_idx <= 4'h0;
                  beat_total <= beats_of(blen);
                  // Four-beat order ignores type; no-wrap only honoured at length 4
                  burst_il <= burst_interleave && (blen == SMRB_BLEN8);
                  burst_nw <= burst_no_wrap && (blen == SMRB_BLEN4);
                  burst_wr_ap <= col_write && col_ap;
               end
            end
            SMRB_BURST: begin
               beat_idx <= beat_idx + 4'h1;
               if (last_now) begin
                  state <= SMRB_IDLE;
               end
            end
         endcase
      end
   end

   // Beat outputs registered for clean timing
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         beat_valid <= 1'b0;
         beat_col <= '0;
         beat_last <= 1'b0;
      end else begin
         beat_valid <= (state == SMRB_BURST);
         beat_col <= burst_nw ? nw_col : wrap_col;
         beat_last <= (state == SMRB_BURST) && last_now;
      end
   end

   // ==========================================
   // Write recovery before auto-precharge
   wire burst_end = (state == SMRB_BURST) && last_now;
   // [RL11] count recovery cycles then precharge
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_pending <= 1'b0;
         wr_count <= 4'h0;
         precharge_start <= 1'b0;
      end else begin
         precharge_start <= 1'b0;
         if (burst_end && burst_wr_ap) begin
            wr_pending <= 1'b1;
            wr_count <= write_recovery_cycles - 4'h1;
         end else if (wr_pending) begin
            if (wr_count == 4'h0) begin
               wr_pending <= 1'b0;
               precharge_start <= 1'b1;
            end else begin
               wr_count <= wr_count - 4'h1;
            end
         end
      end
   end

   // ==========================================
   // Checks
   // Sequences name the steps of the read, column and calibration commands so the properties read as protocol
   sequence s_cal_done_fault;
      zq_cal_done && !zq_locked && (zq_test_code == `SMRB_ZQ_GND);
   endsequence
   sequence s_burst_start;
      state == SMRB_IDLE && col_req;
   endsequence
   sequence s_info_read;
      mrr_req && mr_addr == `SMRB_ADDR_INFO;
   endsequence
   sequence s_other_read;
      mrr_req && mr_addr != `SMRB_ADDR_INFO;
   endsequence
   sequence s_busy_cmd;
      state == SMRB_BURST && col_req && !last_now;
   endsequence

   // [RL1] busy bit
   init_bit_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL1]
      info_word[0] == (init_count < INIT_CYCLES)) else $error("init bit wrong");

   // [RL2] fixed bits
   fixed_bits_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL2]
      info_word[7:5] == 3'h0 && info_word[2:1] == 2'h0) else $error("fixed bits wrong");

   // [RL5] result held
   zq_hold_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL5]
      !zq_cal_done |=> $stable(zq_result)) else $error("zq result moved");

   // [RL6] fault locks
   zq_lock_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL6]
      s_cal_done_fault |=> factory_trim && !zq_cal_start) else $error("fault not locked");

   // [RL6] calibration ignored
   // Once locked, no request may reach the calibration engine again
   cal_blocked_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL6]
      zq_locked |-> !zq_cal_start) else $error("calibration not ignored");

   // [RL18] info read answer
   mrr_answer_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL18]
      s_info_read |=> mrr_valid && mrr_data == $past(info_word)) else $error("read answer wrong");

   // [RL20] other reads strobe
   // Controller still sees a strobe, so its read pipeline never stalls
   other_read_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL20]
      s_other_read |=> mrr_strobe && mrr_data == 8'h00) else $error("other read wrong");

   // [RL18] feature write
   feat_write_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL18]
      mrw_req && mr_addr == `SMRB_ADDR_FEAT |=> feat == $past(mr_wdata)) else $error("feature not written");

   // [RL12] even start column
   low_col_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL12]
      state == SMRB_BURST |-> start_col[0] == 1'b0) else $error("start column odd");

   // [RL13] first beat is start
   start_zero_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL13]
      s_burst_start |=> start_col[0] == 1'b0 ##1 beat_valid && beat_col == $past(start_col, 1))
      else $error("first beat not start");

   // [RL8] four-beat length
   // Beat outputs trail the sequencer by one register stage
   bl4_len_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL8]
      (s_burst_start and (blen == SMRB_BLEN4)) |=> ##4 beat_last ##0 state == SMRB_IDLE)
      else $error("four-beat length wrong");

   // [RL14] eight-beat length
   bl8_len_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL14]
      (s_burst_start and (blen == SMRB_BLEN8)) |=> ##8 beat_last) else $error("eight-beat length wrong");

   // [RL15] sixteen-beat length
   bl16_len_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL15]
      (s_burst_start and (blen == SMRB_BLEN16)) |=> ##16 beat_last) else $error("sixteen-beat length wrong");

   // [RL13] busy command refused
   // A command during a burst must not disturb the running order
   busy_refuse_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL13]
      s_busy_cmd |=> state == SMRB_BURST && start_col == $past(start_col)) else $error("command taken mid-burst");

   // [RL11] recovery delay
   // Counter reload plus registered pulse adds one cycle after the count
   precharge_a: assert property (@(posedge clk_sys) disable iff (rst) // [RL11]
      burst_end && burst_wr_ap && write_recovery_cycles == 4'h3 |=> !precharge_start [*3] ##1 precharge_start)
      else $error("precharge timing");

endmodule : smrb_mode_regs
`default_nettype wire

// ===== tb/smrb_ctrl_model.sv
// Memory controller model issuing mode register and column commands
`timescale 1ns/100ps
`default_nettype none
module smrb_ctrl_model (
   input wire logic clk_sys,
   input wire logic mrr_valid,
   input wire logic mrr_strobe,
   input wire logic [7:0] mrr_data,
   output logic mrr_req,
   output logic mrw_req,
   output logic [7:0] mr_addr,
   output logic [7:0] mr_wdata,
   output logic col_req,
   output logic col_write,
   output logic col_ap,
   output logic [9:0] col_addr
);
   // Idle bus at time zero
   initial begin
      {mrr_req, mrw_req, mr_addr, mr_wdata, col_req, col_write, col_ap, col_addr} = '0;
   end

   task automatic mr_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      mrw_req <= 1'b1;
      mr_addr <= a;
      mr_wdata <= d;
      @(posedge clk_sys);
      mrw_req <= 1'b0;
      mr_addr <= ~a; // Stale bus shows garbage
      mr_wdata <= ~d;
   endtask : mr_write

   task automatic mr_read(input logic [7:0] a, output logic [7:0] d, output logic [1:0] s);
      @(posedge clk_sys);
      mrr_req <= 1'b1;
      mr_addr <= a;
      @(posedge clk_sys);
      mrr_req <= 1'b0;
      mr_addr <= ~a;
      @(posedge clk_sys);
      d = mrr_data;
      s = {mrr_valid, mrr_strobe};
   endtask : mr_read

   task automatic col_cmd(input logic [9:0] c, input logic w, input logic ap);
      @(posedge clk_sys);
      col_req <= 1'b1;
      col_addr <= c;
      col_write <= w;
      col_ap <= ap;
      @(posedge clk_sys);
      col_req <= 1'b0;
      col_addr <= ~c; // Address only valid with request
   endtask : col_cmd
endmodule : smrb_ctrl_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the mode register block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end
module testbench;
   import smrb_pkg::*;
   typedef struct {logic [7:0] f; logic [9:0] c; logic [63:0] s; int n;} smrb_row_t;
   logic clk_sys, rst, zq_cal_done, zq_cal_req, mrr_req, mrw_req, col_req, col_write, col_ap;
   logic mrr_valid, mrr_strobe, zq_cal_start, factory_trim, beat_valid, beat_last;
   logic burst_interleave, burst_no_wrap, precharge_start;
   logic [1:0] zq_test_code, sv;
   logic [7:0] mr_addr, mr_wdata, mrr_data, rd;
   logic [9:0] col_addr, beat_col;
   logic [2:0] burst_len_code;
   logic [3:0] write_recovery_cycles;
   int fail_count, n_checks, k, lat;
   // Feature byte, start column, expected beat nibbles (beat 0 lowest), beats
   smrb_row_t rows [7] = '{'{8'h22, 10'h10a, 64'h98ba, 4}, '{8'h4a, 10'h001, 64'h3210, 4},
      '{8'h72, 10'h006, 64'h9876, 4}, '{8'h83, 10'h0f6, 64'h54321076, 8},
      '{8'hab, 10'h00a, 64'hdcfe98ba, 8}, '{8'hc4, 10'h3fe, 64'hdcba9876543210fe, 16},
      '{8'h2b, 10'h006, 64'h10325476, 8}};

   smrb_mode_regs #(.INIT_CYCLES(5), .COL_W(10)) dut (.clk_sys, .rst, .mrr_req, .mrw_req,
      .mr_addr, .mr_wdata, .zq_cal_done, .zq_test_code, .zq_cal_req, .col_req, .col_write,
      .col_ap, .col_addr, .mrr_valid, .mrr_strobe, .mrr_data, .zq_cal_start, .factory_trim,
      .beat_valid, .beat_col, .beat_last, .burst_len_code, .burst_interleave, .burst_no_wrap,
      .write_recovery_cycles, .precharge_start);
   smrb_ctrl_model ctrl (.clk_sys, .mrr_valid, .mrr_strobe, .mrr_data, .mrr_req, .mrw_req,
      .mr_addr, .mr_wdata, .col_req, .col_write, .col_ap, .col_addr);

   // ==========================================
   // Clock, verdict and shared steps
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : results

   task automatic zq_done(input logic [1:0] c);
      @(posedge clk_sys);
      zq_cal_done <= 1'b1;
      zq_test_code <= c;
      @(posedge clk_sys);
      zq_cal_done <= 1'b0;
      zq_test_code <= ~c; // Code moves without a done pulse
   endtask : zq_done

   // Reset, then defaults and busy flag
   task automatic do_reset();
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      `CHK(burst_len_code, 3'h2)
      `CHK(write_recovery_cycles, 4'h3)
      ctrl.mr_read(8'h00, rd, sv);
      `CHK(rd, 8'h01)
      repeat (8) @(posedge clk_sys);
      ctrl.mr_read(8'h00, rd, sv);
      `CHK(rd, 8'h00)
      `CHK(sv, 2'b11)
   endtask : do_reset

   // One burst; a second command mid-burst must be ignored
   task automatic run_row(input smrb_row_t r);
      ctrl.mr_write(8'h01, r.f);
      @(posedge clk_sys);
      `CHK(burst_len_code, r.f[2:0])
      `CHK({burst_no_wrap, burst_interleave}, r.f[4:3])
      `CHK(write_recovery_cycles, {1'b0, r.f[7:5]} + 4'h2)
      ctrl.col_cmd(r.c, 1'b1, 1'b1);
      ctrl.col_cmd(r.c ^ 10'h004, 1'b0, 1'b0);
      k = 0;
      while (beat_valid !== 1'b1 && k < 6) begin
         @(posedge clk_sys);
         k++;
      end
      for (int i = 0; i < r.n; i++) begin
         `CHK({beat_valid, beat_col}, {1'b1, r.c[9:4], r.s[4*i +: 4]})
         `CHK(beat_last, 1'(i == r.n - 1))
         @(posedge clk_sys);
      end
      `CHK(beat_valid, 1'b0)
      lat = 1;
      while (precharge_start !== 1'b1 && lat < 20) begin
         @(posedge clk_sys);
         lat++;
      end
      `CHK(lat, int'(r.f[7:5]) + 2)
   endtask : run_row

   // ==========================================
   // Main sequence
   initial begin
      {zq_cal_done, zq_test_code, zq_cal_req} = '0;
      rst = 1'b1;
      do_reset();
      foreach (rows[i]) run_row(rows[i]);
      $display("burst rows done");
      // Read-only and unmapped places change nothing
      ctrl.mr_write(8'h00, 8'hff);
      ctrl.mr_write(8'h02, 8'h24);
      ctrl.mr_read(8'h00, rd, sv);
      `CHK(rd, 8'h00)
      `CHK(burst_len_code, 3'h3)
      ctrl.mr_read(8'h01, rd, sv);
      `CHK(sv, 2'b11)
      ctrl.mr_write(8'h01, 8'h22);
      ctrl.col_cmd(10'h000, 1'b1, 1'b0);
      lat = 0;
      repeat (16) begin
         @(posedge clk_sys);
         lat += int'(precharge_start === 1'b1);
      end
      `CHK(lat, 0)
      $display("register tests done");
      // Pass result, then supply result locks calibration out
      zq_done(2'h3);
      ctrl.mr_read(8'h00, rd, sv);
      `CHK({factory_trim, rd}, 9'h018)
      zq_cal_req <= 1'b1;
      @(posedge clk_sys);
      `CHK(zq_cal_start, 1'b1)
      zq_done(2'h1);
      ctrl.mr_read(8'h00, rd, sv);
      `CHK({factory_trim, zq_cal_start, rd}, 10'h208)
      zq_done(2'h3);
      ctrl.mr_read(8'h00, rd, sv);
      `CHK(rd, 8'h08)
      zq_cal_req <= 1'b0;
      $display("zq tests done");
      do_reset();
      zq_done(2'h2);
      ctrl.mr_read(8'h00, rd, sv);
      `CHK({factory_trim, rd}, 9'h110)
      $display("reset tests done");
      results();
   end

   // Watchdog well beyond the expected run
   initial begin
      repeat (3000) @(posedge clk_sys);
      fail_count++;
      results();
   end
endmodule : testbench
`default_nettype wire
